// File: design/rtcal_alarm.sv
// Alarm compare, alarm flag and shared open-drain interrupt pin.
// Assumes a register port decoded elsewhere from the serial bus,
// calendar counters and timer logic on the same SYS_CLK.

`timescale 1ns/10ps

`include "rtcal_map.svh"

module rtcal_alarm
	import rtcal_pkg::*;
(
	input  wire logic        SYS_CLK,
	input  wire logic        RST_N,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	input  wire logic [3:0]  REG_ADDR,
	input  wire rtcal_byte_t REG_WDATA,
	input  wire rtcal_time_s CUR_TIME,
	input  wire logic        TIMER_EVENT,
	input  wire logic        TIMER_PULSE_ACT,
	output rtcal_byte_t      RD_DATA,
	output logic             RD_VALID,
	output logic             ALARM_EVENT,
	output logic             TIMER_PULSE_SEL,
	output logic             TIMER_IRQ_EN,
	output logic             IRQ_OUT_N_O,
	output logic             IRQ_OUT_N_OE
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	rtcal_byte_t alarm_q [`RTCAL_NUM_FIELD];
	logic [6:0]  counter [`RTCAL_NUM_FIELD];
	logic [6:0]  mask    [`RTCAL_NUM_FIELD];
	logic [3:0]  field_hit;
	logic [3:0]  field_dis;
	logic        all_dis;
	logic        match_now;
	logic        match_prev_q;
	logic        alarm_evt;
	logic        wr_ctrl;
	logic        clr_af;
	logic        clr_tf;
	logic        af_q;
	logic        af_d;
	logic        tf_q;
	logic        tf_d;
	logic        aie_q;
	logic        aie_d;
	logic        tie_q;
	logic        tie_d;
	logic        tps_q;
	logic        tps_d;
	logic        timer_irq_d;
	logic        irq_d;
	rtcal_byte_t rd_d;

	// ----------------------------------------------------------------
	// Counter view per field
	// ----------------------------------------------------------------
	assign counter[0] = CUR_TIME.minute;
	// Hour counter already runs in 24-hour BCD, compared as is
	assign counter[1] = {1'b0, CUR_TIME.hour}; // RL12
	assign counter[2] = {1'b0, CUR_TIME.day};
	assign counter[3] = {4'h0, CUR_TIME.weekday};

	assign mask[0] = `RTCAL_MASK_MIN;
	assign mask[1] = `RTCAL_MASK_HOUR;
	assign mask[2] = `RTCAL_MASK_DAY;
	assign mask[3] = `RTCAL_MASK_WDAY;

	// ----------------------------------------------------------------
	// Alarm registers and field compare
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `RTCAL_NUM_FIELD; gi++) begin : g_field
			localparam logic [3:0] AOFS = 4'(`RTCAL_OFS_AMIN + gi);

			always_ff @(posedge SYS_CLK or negedge RST_N) begin
				if (!RST_N) begin
					alarm_q[gi] <= `RTCAL_RST_ALARM;
				end else if (REG_WR && REG_ADDR == AOFS) begin
					alarm_q[gi] <= REG_WDATA;
				end
			end

			assign field_dis[gi] = alarm_q[gi][`RTCAL_BIT_DIS];

			rtcal_field_cmp u_cmp (
				.alarm_reg  (alarm_q[gi]),
				.counter    (counter[gi]),
				.valid_mask (mask[gi]),
				.hit        (field_hit[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Match detection
	// ----------------------------------------------------------------
	assign all_dis = &field_dis;
	// All fields off means no alarm at all, not a match every cycle
	assign match_now = (&field_hit) & ~all_dis; // RL1 RL4

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			match_prev_q <= 1'b0;
		end else begin
			match_prev_q <= match_now;
		end
	end

	// Edge only; a match lasting a minute gives one event.
	// A settings change that newly matches also counts as an edge,
	// hence software should drop the enable while editing.
	assign alarm_evt = match_now & ~match_prev_q; // RL13 RL14

	// ----------------------------------------------------------------
	// Control register next state
	// ----------------------------------------------------------------
	assign wr_ctrl = REG_WR && REG_ADDR == `RTCAL_OFS_CTRL2;
	// Only a written zero clears; a written one is ignored
	assign clr_af = wr_ctrl && !REG_WDATA[`RTCAL_BIT_AF]; // RL6
	assign clr_tf = wr_ctrl && !REG_WDATA[`RTCAL_BIT_TF];

	// Set wins over a clear in the same cycle
	assign af_d = alarm_evt | (af_q & ~clr_af); // RL1 RL5 RL11
	assign tf_d = TIMER_EVENT | (tf_q & ~clr_tf);

	assign aie_d = wr_ctrl ? REG_WDATA[`RTCAL_BIT_AIE] : aie_q;
	assign tie_d = wr_ctrl ? REG_WDATA[`RTCAL_BIT_TIE] : tie_q;
	assign tps_d = wr_ctrl ? REG_WDATA[`RTCAL_BIT_TPS] : tps_q;

	// ----------------------------------------------------------------
	// Flags
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			af_q <= 1'(`RTCAL_RST_CTRL2 >> `RTCAL_BIT_AF);
		end else begin
			af_q <= af_d; // RL5
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			tf_q <= 1'b0;
		end else begin
			tf_q <= tf_d;
		end
	end

	// ----------------------------------------------------------------
	// Enables and timer mode
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			aie_q <= 1'b0;
			tie_q <= 1'b0;
			tps_q <= 1'b0;
		end else begin
			aie_q <= aie_d;
			tie_q <= tie_d;
			tps_q <= tps_d;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			TIMER_PULSE_SEL <= 1'b0;
			TIMER_IRQ_EN    <= 1'b0;
		end else begin
			TIMER_PULSE_SEL <= tps_d;
			TIMER_IRQ_EN    <= tie_d;
		end
	end

	// ----------------------------------------------------------------
	// Shared interrupt pin
	// ----------------------------------------------------------------
	// Pulse mode: the timer shapes the low time itself
	assign timer_irq_d = tie_d & (tps_d ? TIMER_PULSE_ACT : tf_d);
	// Built from next-state values so clear or enable acts on the same edge
	assign irq_d = (af_d & aie_d) | timer_irq_d; // RL2 RL8 RL9 RL10 RL15

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			IRQ_OUT_N_OE <= 1'b0;
		end else begin
			IRQ_OUT_N_OE <= irq_d; // RL2 RL15
		end
	end

	// Pad level is always low; only the enable moves
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			IRQ_OUT_N_O <= 1'b0;
		end else begin
			IRQ_OUT_N_O <= 1'b0; // RL17
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ALARM_EVENT <= 1'b0;
		end else begin
			ALARM_EVENT <= alarm_evt;
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_comb begin
		rd_d = 8'h00;
		case (REG_ADDR)
			`RTCAL_OFS_CTRL2: begin
				rd_d = {3'b000, tps_q, af_q, tf_q, aie_q, tie_q}; // RL7
			end
			`RTCAL_OFS_MIN:   rd_d = {1'b0, CUR_TIME.minute};
			`RTCAL_OFS_HOUR:  rd_d = {2'b00, CUR_TIME.hour};
			`RTCAL_OFS_DAY:   rd_d = {2'b00, CUR_TIME.day};
			`RTCAL_OFS_WDAY:  rd_d = {5'h00, CUR_TIME.weekday};
			`RTCAL_OFS_AMIN:  rd_d = alarm_q[0];
			`RTCAL_OFS_AHOUR: rd_d = alarm_q[1];
			`RTCAL_OFS_ADAY:  rd_d = alarm_q[2];
			`RTCAL_OFS_AWDAY: rd_d = alarm_q[3];
			default:          rd_d = 8'h00;
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			RD_DATA  <= 8'h00;
			RD_VALID <= 1'b0;
		end else begin
			RD_VALID <= REG_RD;
			if (REG_RD) begin
				RD_DATA <= rd_d;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK);
	endclocking

	default disable iff (!RST_N);

	chk_match_sets_flag: assert property ( // RL1
		alarm_evt |=> af_q ##0 ALARM_EVENT
	) else $error("alarm flag not set after match");

	chk_alarm_drives_pin: assert property ( // RL2
		alarm_evt && aie_q && !wr_ctrl |=> IRQ_OUT_N_OE
	) else $error("pin not low after enabled match");

	chk_field_ignored: assert property ( // RL3
		field_dis[0] && (alarm_q[0][6:0] != counter[0]) |-> field_hit[0]
	) else $error("disabled minute field still compared");

	chk_all_off_quiet: assert property ( // RL4
		all_dis |-> !match_now && !alarm_evt
	) else $error("alarm event with all fields disabled");

	chk_flag_holds: assert property ( // RL5
		af_q && !clr_af |=> af_q
	) else $error("alarm flag dropped without clear");

	chk_flag_clears: assert property ( // RL5
		af_q && clr_af && !alarm_evt |=> !af_q
	) else $error("alarm flag not cleared by zero write");

	chk_one_write_nop: assert property ( // RL6
		!af_q && wr_ctrl && REG_WDATA[`RTCAL_BIT_AF] && !alarm_evt |=> !af_q
	) else $error("written one changed alarm flag");

	chk_read_flag: assert property ( // RL7
		REG_RD && REG_ADDR == `RTCAL_OFS_CTRL2
		|=> RD_VALID && RD_DATA[`RTCAL_BIT_AF] == $past(af_q)
	) else $error("read of alarm flag wrong");

	chk_clear_release: assert property ( // RL8
		af_q && clr_af && !alarm_evt && !timer_irq_d |=> !IRQ_OUT_N_OE
	) else $error("pin held after flag clear");

	chk_disable_release: assert property ( // RL9
		wr_ctrl && !REG_WDATA[`RTCAL_BIT_AIE] && !timer_irq_d
		|=> !IRQ_OUT_N_OE [*1] ##1 (!IRQ_OUT_N_OE || $past(timer_irq_d) || aie_q)
	) else $error("pin held with alarm enable off");

	// A zero in the same write clears the flag, so no pin then
	chk_enable_asserts: assert property ( // RL10
		wr_ctrl && REG_WDATA[`RTCAL_BIT_AIE] && REG_WDATA[`RTCAL_BIT_AF] && af_q
		|=> IRQ_OUT_N_OE
	) else $error("pin not low on enable with flag set");

	chk_poll_only: assert property ( // RL11
		alarm_evt && !aie_d && !timer_irq_d |=> af_q && !IRQ_OUT_N_OE
	) else $error("poll mode wrong");

	chk_single_event: assert property ( // RL13
		alarm_evt |=> !alarm_evt throughout (match_now [*2])
		or ##1 !match_now
	) else $error("repeated event during one match");

	chk_timer_shares: assert property ( // RL15
		timer_irq_d |=> IRQ_OUT_N_OE
	) else $error("timer request not on shared pin");

	chk_pin_low_only: assert property ( // RL17
		$rose(IRQ_OUT_N_OE) |-> IRQ_OUT_N_O == 1'b0
	) else $error("pin driven high");

	chk_disabled_quiet: assert property ( // RL9
		!aie_d && !timer_irq_d |=> !IRQ_OUT_N_OE
	) else $error("pin low with alarm enable off");

	chk_event_pulse: assert property ( // RL13
		ALARM_EVENT |=> !ALARM_EVENT
	) else $error("alarm event longer than one cycle");

	cov_alarm_irq: cover property (
		alarm_evt && aie_q ##1 IRQ_OUT_N_OE
	);

	cov_clear_irq: cover property (
		IRQ_OUT_N_OE && af_q && clr_af ##1 !af_q
	);

	cov_late_enable: cover property (
		af_q && !aie_q ##1 aie_q ##0 IRQ_OUT_N_OE
	);

	cov_set_over_clear: cover property (
		alarm_evt && clr_af ##1 af_q
	);

	cov_poll_event: cover property (
		alarm_evt && !aie_q ##1 af_q && !IRQ_OUT_N_OE
	);

endmodule

// File: design/rtcal_field_cmp.sv
// One alarm field compared against its calendar counter.
// Assumes the counter is BCD and stable on the comparing clock.

`timescale 1ns/10ps

`include "rtcal_map.svh"

module rtcal_field_cmp
	import rtcal_pkg::*;
(
	input  wire rtcal_byte_t alarm_reg,
	input  wire logic [6:0]  counter,
	input  wire logic [6:0]  valid_mask,
	output logic             hit
);

	logic field_dis;
	logic equal;

	assign field_dis = alarm_reg[`RTCAL_BIT_DIS];
	// Unused BCD bits dropped on both sides
	assign equal = ((alarm_reg[6:0] ^ counter) & valid_mask) == 7'h00; // RL16
	assign hit = field_dis | equal; // RL3

endmodule

// File: design/rtcal_map.svh
// Register map, field positions and reset values of the alarm block.
// Assumes the includer compiles it once; values are plain constants.
//
// Operation
// (RL1) A match of every enabled alarm field with the current time sets the alarm flag.
// (RL2) A match while the alarm interrupt enable is one pulls the interrupt pin low.
// (RL3) A field whose top disable bit is one takes no part in the comparison.
// (RL4) With all four disable bits at one no alarm event ever occurs.
// (RL5) The alarm flag holds once set and a write of zero clears it.
// (RL6) Writing one to the alarm flag leaves it unchanged.
// (RL7) Reading the alarm flag returns one after an event until it is cleared.
// (RL8) Clearing the alarm flag releases a low interrupt pin at once.
// (RL9) A zero alarm enable releases the pin and keeps alarm events off it.
// (RL10) Setting the alarm enable while the flag is one pulls the pin low at once.
// (RL11) With the enable at zero a match still sets the flag while the pin stays released.
// (RL12) The hour field is compared in 24-hour form.
// (RL13) An event is raised only on entering the match, not while it lasts.
// (RL14) Software should clear the alarm enable before changing alarm settings.
// (RL15) The interrupt pin is shared by alarm and timer events, told apart by the flags.
// (RL16) Fields are BCD: minute seven bits, hour and day six, weekday three, rest ignored.
// (RL17) The interrupt pin is open drain: driven low or released, never driven high.

`ifndef RTCAL_MAP_SVH
`define RTCAL_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RTCAL_OFS_CTRL2  4'h1
`define RTCAL_OFS_MIN    4'h3
`define RTCAL_OFS_HOUR   4'h4
`define RTCAL_OFS_DAY    4'h5
`define RTCAL_OFS_WDAY   4'h6
`define RTCAL_OFS_AMIN   4'h9
`define RTCAL_OFS_AHOUR  4'hA
`define RTCAL_OFS_ADAY   4'hB
`define RTCAL_OFS_AWDAY  4'hC

// ----------------------------------------------------------------
// Field positions of control_two and the alarm registers
// ----------------------------------------------------------------
`define RTCAL_BIT_TIE  0
`define RTCAL_BIT_AIE  1
`define RTCAL_BIT_TF   2
`define RTCAL_BIT_AF   3
`define RTCAL_BIT_TPS  4
`define RTCAL_BIT_DIS  7

// ----------------------------------------------------------------
// Valid BCD bits per field
// ----------------------------------------------------------------
`define RTCAL_MASK_MIN   7'h7F
`define RTCAL_MASK_HOUR  7'h3F
`define RTCAL_MASK_DAY   7'h3F
`define RTCAL_MASK_WDAY  7'h07

// ----------------------------------------------------------------
// Reset values and field count
// ----------------------------------------------------------------
`define RTCAL_RST_ALARM  8'h80
`define RTCAL_RST_CTRL2  8'h00
`define RTCAL_NUM_FIELD  4

`endif

// File: design/rtcal_pkg.sv
// Types shared by the alarm block and its surroundings.
// Assumes the calendar counters deliver BCD values on the same clock.

package rtcal_pkg;

	// ----------------------------------------------------------------
	// Current calendar time, BCD
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [6:0] minute;
		logic [5:0] hour;
		logic [5:0] day;
		logic [2:0] weekday;
	} rtcal_time_s;

	typedef logic [7:0] rtcal_byte_t;

endpackage

// File: verif/rtcal_alarm_tb.sv
// Self-checking bench of the alarm compare and interrupt pin.
// Assumes a pull-up on the open-drain pin and BCD time from the bench.

`timescale 1ns/10ps

module rtcal_alarm_tb
	import rtcal_pkg::*;
();
	logic        sys_clk;
	logic        rst_n;
	rtcal_time_s cur_time;
	logic        timer_event;
	logic        timer_pulse_act;
	logic        reg_wr, reg_rd, rd_valid, alarm_event;
	logic        timer_pulse_sel, timer_irq_en, irq_out_n_o, irq_out_n_oe;
	logic [3:0]  reg_addr;
	rtcal_byte_t reg_wdata, rd_data;
	wire         irq_n = irq_out_n_oe ? irq_out_n_o : 1'b1;
	int          err_count = 0;
	int          tests_run = 0;

	rtcal_alarm uut (
		.SYS_CLK(sys_clk), .RST_N(rst_n), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .CUR_TIME(cur_time),
		.TIMER_EVENT(timer_event), .TIMER_PULSE_ACT(timer_pulse_act),
		.RD_DATA(rd_data), .RD_VALID(rd_valid), .ALARM_EVENT(alarm_event),
		.TIMER_PULSE_SEL(timer_pulse_sel), .TIMER_IRQ_EN(timer_irq_en),
		.IRQ_OUT_N_O(irq_out_n_o), .IRQ_OUT_N_OE(irq_out_n_oe)
	);

	rtcal_host host (
		.sys_clk(sys_clk), .rd_data(rd_data), .rd_valid(rd_valid), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic finish_test();
		$display("mismatches %0d of %0d checks", err_count, tests_run);
		if (err_count == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk_byte(input rtcal_byte_t e, input rtcal_byte_t a);
		tests_run++;
		if (a !== e) begin
			err_count++;
			$display("[FAIL] %0t exp %h got %h", $time, e, a);
		end
	endtask

	task automatic chk_bit(input logic e, input logic a);
		tests_run++;
		if (a !== e) begin
			err_count++;
			$display("[FAIL] %0t exp %h got %h", $time, e, a);
		end
	endtask

	task automatic rd_chk(input logic [3:0] a, input rtcal_byte_t e);
		rtcal_byte_t d;
		logic        ok;
		host.rd(a, d, ok);
		if (ok !== 1'b1) begin
			err_count++;
			$display("[FAIL] %0t exp %h got %h", $time, 1'b1, ok);
			finish_test();
		end else begin
			chk_byte(e, d);
		end
	endtask

	// Day 15 and weekday 3 stay fixed; only minute and hour move
	function automatic rtcal_time_s tm(input logic [6:0] m, input logic [5:0] h);
		return '{m, h, 6'h15, 3'h3};
	endfunction

	task automatic st(input rtcal_time_s t);
		@(posedge sys_clk);
		cur_time <= t;
	endtask

	task automatic ev(input logic e);
		@(posedge sys_clk);
		#1;
		chk_bit(e, alarm_event);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		rd_chk(4'h1, 8'h00);
		for (int i = 9; i <= 12; i++) begin
			rd_chk(4'(i), 8'h80);
		end
		rd_chk(4'h0, 8'h00);
		host.wr(4'h1, 8'h08);
		rd_chk(4'h1, 8'h00);
		host.wr(4'h3, 8'h55);
		rd_chk(4'h3, 8'h00);
	endtask

	task automatic t_alarm();
		host.wr(4'h1, 8'h00);
		host.wr(4'h9, 8'h30);
		// Bit 6 of the hour alarm lies outside the BCD hour
		host.wr(4'hA, 8'h59);
		host.wr(4'hB, 8'h15);
		host.wr(4'h1, 8'h02);
		st(tm(7'h30, 6'h19));
		ev(1'b1);
		chk_bit(1'b0, irq_n);
		repeat (3) ev(1'b0);
		rd_chk(4'h1, 8'h0A);
		host.wr(4'h1, 8'h0A);
		rd_chk(4'h1, 8'h0A);
		chk_bit(1'b0, irq_n);
		host.wr(4'h1, 8'h02);
		chk_bit(1'b1, irq_n);
		ev(1'b0);
		rd_chk(4'h1, 8'h02);
		st(tm(7'h31, 6'h19));
		ev(1'b0);
		st(tm(7'h30, 6'h19));
		ev(1'b1);
		host.wr(4'h1, 8'h08);
		chk_bit(1'b1, irq_n);
	endtask

	task automatic t_poll();
		host.wr(4'h1, 8'h00);
		st(tm(7'h31, 6'h19));
		ev(1'b0);
		// Clear lands on the match edge; the set must win
		fork
			host.wr(4'h1, 8'h00);
			st(tm(7'h30, 6'h19));
		join
		chk_bit(1'b1, alarm_event);
		chk_bit(1'b1, irq_n);
		rd_chk(4'h1, 8'h08);
		host.wr(4'h1, 8'h0A);
		chk_bit(1'b0, irq_n);
		host.wr(4'h1, 8'h00);
	endtask

	task automatic t_mask();
		st(tm(7'h30, 6'h07));
		ev(1'b0);
		host.wr(4'hA, 8'h80);
		ev(1'b1);
		host.wr(4'h1, 8'h00);
		host.wr(4'h9, 8'h80);
		host.wr(4'hB, 8'h80);
		st(tm(7'h31, 6'h07));
		st(tm(7'h30, 6'h07));
		repeat (3) ev(1'b0);
		rd_chk(4'h1, 8'h00);
	endtask

	task automatic t_timer();
		host.wr(4'h1, 8'h01);
		@(posedge sys_clk);
		timer_event <= 1'b1;
		@(posedge sys_clk);
		timer_event <= 1'b0;
		#1;
		chk_bit(1'b0, irq_n);
		chk_bit(1'b0, irq_out_n_o);
		rd_chk(4'h1, 8'h05);
		host.wr(4'h1, 8'h11);
		chk_bit(1'b1, irq_n);
		chk_bit(1'b1, timer_pulse_sel);
		chk_bit(1'b1, timer_irq_en);
		@(posedge sys_clk);
		timer_pulse_act <= 1'b1;
		@(posedge sys_clk);
		#1;
		chk_bit(1'b0, irq_n);
		@(posedge sys_clk);
		timer_pulse_act <= 1'b0;
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	initial begin
		rst_n           = 1'b0;
		cur_time        = tm(7'h00, 6'h00);
		timer_event     = 1'b0;
		timer_pulse_act = 1'b0;
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_regs();
		t_alarm();
		t_poll();
		t_mask();
		t_timer();
		finish_test();
	end
endmodule

// File: verif/rtcal_host.sv
// Host model: register writes and reads on the strobe port of the alarm block.
// Assumes the same SYS_CLK as the block; the bench calls the tasks in turn.

`timescale 1ns/10ps

module rtcal_host
	import rtcal_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire rtcal_byte_t rd_data,
	input  wire logic        rd_valid,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic [3:0]       reg_addr,
	output rtcal_byte_t      reg_wdata
);
	initial begin
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 4'h0;
		reg_wdata = 8'h00;
	end

	// Returns 1 ns after the taking edge, so callers see settled outputs
	task automatic wr(input logic [3:0] a, input rtcal_byte_t d);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
		// Released data does not keep the old value
		reg_wdata <= ~d;
		#1;
	endtask

	task automatic rd(input logic [3:0] a, output rtcal_byte_t d, output logic ok);
		ok = 1'b0;
		d  = 8'h00;
		@(posedge sys_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		// Look 1 ns after each edge, once the registered answer has settled
		repeat (4) begin
			#1;
			if (rd_valid === 1'b1) begin
				d  = rd_data;
				ok = 1'b1;
				break;
			end
			@(posedge sys_clk);
		end
	endtask
endmodule
